/* hw/twbpe_pkg.sv */
// constants and types for the two-wire bus protocol engine
package twbpe_pkg;
  // ----------------------------------------------------------------
  // timing, in nanoseconds except the link period in picoseconds, with counts in link clock cycles
  // ----------------------------------------------------------------
  localparam int LINK_PERIOD_PS = 6000;
  localparam int T_LOW_NS = 1300;
  localparam int T_HIGH_NS = 600;
  localparam int T_HOLD_NS = 300;
  localparam int T_START_NS = 600;
  localparam int T_STOP_NS = 600;
  localparam int T_BUF_NS = 1300;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] LOW_CNT = CNT_W'((T_LOW_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam logic [CNT_W-1:0] HIGH_CNT = CNT_W'((T_HIGH_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'((T_HOLD_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam logic [CNT_W-1:0] START_CNT = CNT_W'((T_START_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam logic [CNT_W-1:0] STOP_CNT = CNT_W'((T_STOP_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam logic [CNT_W-1:0] BUF_CNT = CNT_W'((T_BUF_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam logic [CNT_W-1:0] DRIVE_PT = LOW_CNT - HOLD_CNT;

  // ----------------------------------------------------------------
  // packet layout and addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [3:0] RSVD_TOP = 4'hF;
  localparam logic DIR_READ = 1'b1;
  localparam int SYNC_IN_W = 14;
  localparam int SYNC_OUT_W = 3;

  // ----------------------------------------------------------------
  // commands and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2,
    OP_STOP = 2'h3
  } twbpe_op_t;

  typedef enum logic [3:0] {
    M_IDLE = 4'h0,
    M_WAITFREE = 4'h1,
    M_RS_LOW = 4'h2,
    M_RS_HIGH = 4'h3,
    M_START = 4'h4,
    M_BIT_LOW = 4'h5,
    M_BIT_HIGH = 4'h6,
    M_STOP_LOW = 4'h7,
    M_STOP_HIGH = 4'h8,
    M_STOP_BUF = 4'h9
  } twbpe_mst_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_ADDR_ACK = 3'h2,
    S_DATA = 3'h3,
    S_DATA_ACK = 3'h4,
    S_IGNORE = 3'h5
  } twbpe_slv_t;
endpackage : twbpe_pkg

/* hw/twbpe_sync.sv */
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/100ps
module twbpe_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk) begin
    meta_q <= d;
    sync_q <= meta_q;
  end

  assign q = sync_q;
endmodule : twbpe_sync

/* hw/twbpe_engine.sv */
// two-wire bus protocol engine: master, slave receiver, bus monitor
`timescale 1ns/100ps
module twbpe_engine
  import twbpe_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic bus_clk, // link sampling and timing clock
  input wire logic scl_i, // clock line level
  output logic scl_o, // clock line drive value, always low
  output logic scl_oe, // clock line pull-down enable
  input wire logic sda_i, // data line level
  output logic sda_o, // data line drive value, always low
  output logic sda_oe, // data line pull-down enable
  input wire logic cmd_valid, // command offered
  output logic cmd_ready, // command may be taken
  input wire twbpe_pkg::twbpe_op_t cmd_op, // command code
  input wire logic [7:0] cmd_data, // byte to send
  input wire logic cmd_ack, // ack to send after a read byte
  output logic rsp_valid, // command finished, one cycle
  output logic [7:0] rsp_data, // byte seen on the bus
  output logic rsp_ack, // acknowledge seen in ninth bit
  output logic rsp_arb_lost, // arbitration lost
  output logic rsp_err, // command refused
  input wire logic [6:0] own_addr, // own slave address
  input wire logic gc_en, // accept general call
  input wire logic slv_en, // own address match enabled; general call depends on gc_en only
  input wire logic slv_ack_en, // ack received data bytes
  output logic slv_valid, // slave byte received, one cycle
  output logic [7:0] slv_data, // received slave byte
  output logic slv_gc, // byte came through general call
  output logic bus_busy // bus between start and stop
);
  // ----------------------------------------------------------------
  // system side command and result registers
  // ----------------------------------------------------------------
  logic cmd_rdy_q;
  logic req_tgl_q;
  twbpe_op_t op_q;
  logic [7:0] data_q;
  logic ack_q;
  logic done_seen_q;
  logic slv_seen_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic rsp_ack_q;
  logic rsp_arb_q;
  logic rsp_err_q;
  logic slv_valid_q;
  logic [7:0] slv_data_q;
  logic slv_gc_q;
  logic bus_busy_q;
  logic [SYNC_OUT_W-1:0] to_sys_s;
  logic done_new;
  logic slv_new;

  // ----------------------------------------------------------------
  // link side state
  // ----------------------------------------------------------------
  logic [SYNC_IN_W-1:0] to_link_s;
  logic scl_s;
  logic sda_s;
  logic lrst;
  logic req_s;
  logic [6:0] own_s;
  logic gc_en_s;
  logic slv_en_s;
  logic slv_ack_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic busy_q;
  twbpe_mst_t m_st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic rd_q;
  logic hi_q;
  logic rx_ack_q;
  logic m_scl_low_q;
  logic m_sda_low_q;
  logic m_own_q;
  logic m_empty_q;
  logic req_seen_q;
  logic done_tgl_q;
  logic [7:0] res_data_q;
  logic res_ack_q;
  logic res_arb_q;
  logic res_err_q;
  logic drive_low;
  twbpe_slv_t s_st_q;
  logic [3:0] s_bit_q;
  logic [7:0] s_sh_q;
  logic s_drive_q;
  logic s_gc_q;
  logic own_hit;
  logic gc_hit;
  logic slv_tgl_q;
  logic [7:0] slv_byte_q;
  logic slv_byte_gc_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic pin_lvl_q;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  // pins synchronised first
  twbpe_sync #(.W(SYNC_IN_W)) u_to_link (
    .clk(bus_clk),
    .d({scl_i, sda_i, sys_rst, req_tgl_q, own_addr, gc_en, slv_en, slv_ack_en}),
    .q(to_link_s)
  );
  assign {scl_s, sda_s, lrst, req_s, own_s, gc_en_s, slv_en_s, slv_ack_s} = to_link_s;

  twbpe_sync #(.W(SYNC_OUT_W)) u_to_sys (
    .clk(clk),
    .d({done_tgl_q, slv_tgl_q, busy_q}),
    .q(to_sys_s)
  );
  assign done_new = to_sys_s[2] ^ done_seen_q;
  assign slv_new = to_sys_s[1] ^ slv_seen_q;

  // ----------------------------------------------------------------
  // system side: commands out, results in
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_rdy_q <= 1'b1;
      req_tgl_q <= 1'b0;
      op_q <= OP_START;
      data_q <= 8'h00;
      ack_q <= 1'b0;
    end else if (cmd_valid && cmd_rdy_q) begin
      cmd_rdy_q <= 1'b0;
      req_tgl_q <= ~req_tgl_q;
      op_q <= cmd_op;
      data_q <= cmd_data;
      ack_q <= cmd_ack;
    end else if (done_new) begin
      cmd_rdy_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_seen_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
      rsp_ack_q <= 1'b0;
      rsp_arb_q <= 1'b0;
      rsp_err_q <= 1'b0;
    end else begin
      rsp_valid_q <= done_new;
      if (done_new) begin
        done_seen_q <= to_sys_s[2];
        rsp_data_q <= res_data_q;
        rsp_ack_q <= res_ack_q;
        rsp_arb_q <= res_arb_q;
        rsp_err_q <= res_err_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slv_seen_q <= 1'b0;
      slv_valid_q <= 1'b0;
      slv_data_q <= 8'h00;
      slv_gc_q <= 1'b0;
      bus_busy_q <= 1'b0;
    end else begin
      slv_valid_q <= slv_new;
      bus_busy_q <= to_sys_s[0];
      if (slv_new) begin
        slv_seen_q <= to_sys_s[1];
        slv_data_q <= slv_byte_q;
        slv_gc_q <= slv_byte_gc_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // link side: line edges, start and stop, busy
  // ----------------------------------------------------------------
  always_ff @(posedge bus_clk) begin
    if (lrst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

  always_ff @(posedge bus_clk) begin
    if (lrst) begin
      busy_q <= 1'b0;
    end else if (start_det) begin
      busy_q <= 1'b1;
    end else if (stop_det) begin
      busy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // master
  // ----------------------------------------------------------------
  // receiver drives ninth bit, transmitter drives eight
  assign drive_low = rd_q ? (bit_q == ACK_BIT && ack_q) : (bit_q != ACK_BIT && !sh_q[7]);

  always_ff @(posedge bus_clk) begin
    if (lrst) begin
      m_st_q <= M_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      hi_q <= 1'b0;
      rx_ack_q <= 1'b0;
      m_scl_low_q <= 1'b0;
      m_sda_low_q <= 1'b0;
      m_own_q <= 1'b0;
      m_empty_q <= 1'b0;
      req_seen_q <= 1'b0;
      done_tgl_q <= 1'b0;
      res_data_q <= 8'h00;
      res_ack_q <= 1'b0;
      res_arb_q <= 1'b0;
      res_err_q <= 1'b0;
    end else begin
      unique case (m_st_q)
        M_IDLE: begin
          if (req_s != req_seen_q) begin
            req_seen_q <= req_s;
            res_arb_q <= 1'b0;
            res_err_q <= 1'b0;
            bit_q <= 4'h0;
            hi_q <= 1'b0;
            cnt_q <= LOW_CNT;
            unique case (op_q)
              OP_START: begin
                // repeated start while holding the bus
                if (m_own_q) begin
                  m_sda_low_q <= 1'b0;
                  m_st_q <= M_RS_LOW;
                end else begin
                  m_st_q <= M_WAITFREE;
                end
              end
              OP_WRITE: begin
                if (!m_own_q || (m_empty_q && data_q[7:1] == GC_ADDR && data_q[0] == DIR_READ)) begin
                  res_err_q <= 1'b1;
                  done_tgl_q <= ~done_tgl_q;
                end else begin
                  sh_q <= data_q;
                  rd_q <= 1'b0;
                  m_st_q <= M_BIT_LOW;
                end
              end
              OP_READ: begin
                if (!m_own_q || m_empty_q) begin
                  res_err_q <= 1'b1;
                  done_tgl_q <= ~done_tgl_q;
                end else begin
                  sh_q <= 8'hFF;
                  rd_q <= 1'b1;
                  m_st_q <= M_BIT_LOW;
                end
              end
              OP_STOP: begin
                if (!m_own_q || m_empty_q) begin
                  res_err_q <= 1'b1;
                  done_tgl_q <= ~done_tgl_q;
                end else begin
                  m_st_q <= M_STOP_LOW;
                end
              end
            endcase
          end
        end
        M_WAITFREE: begin
          if (!busy_q) begin
            m_sda_low_q <= 1'b1;
            m_own_q <= 1'b1;
            cnt_q <= START_CNT;
            m_st_q <= M_START;
          end
        end
        M_RS_LOW: begin
          if (cnt_q == '0) begin
            m_scl_low_q <= 1'b0;
            cnt_q <= HIGH_CNT;
            m_st_q <= M_RS_HIGH;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        M_RS_HIGH: begin
          if (!scl_s) begin
            cnt_q <= HIGH_CNT;
          end else if (cnt_q == '0) begin
            m_sda_low_q <= 1'b1;
            cnt_q <= START_CNT;
            m_st_q <= M_START;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        M_START: begin
          if (cnt_q == '0) begin
            m_scl_low_q <= 1'b1;
            m_empty_q <= 1'b1;
            done_tgl_q <= ~done_tgl_q;
            m_st_q <= M_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        M_BIT_LOW: begin
          // data changes only in the low phase
          if (cnt_q == DRIVE_PT) begin
            m_sda_low_q <= drive_low;
          end
          if (cnt_q == '0) begin
            m_scl_low_q <= 1'b0;
            hi_q <= 1'b0;
            cnt_q <= HIGH_CNT;
            m_st_q <= M_BIT_HIGH;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        M_BIT_HIGH: begin
          if (scl_rise && !hi_q) begin
            // high count starts at the real rise
            hi_q <= 1'b1;
            cnt_q <= HIGH_CNT;
            if (bit_q == ACK_BIT) begin
              rx_ack_q <= !sda_s;
            end else begin
              sh_q <= {sh_q[6:0], sda_s};
            end
            if (!rd_q && bit_q != ACK_BIT && !m_sda_low_q && !sda_s) begin
              // release the lines and fall back to listening
              m_sda_low_q <= 1'b0;
              m_own_q <= 1'b0;
              res_arb_q <= 1'b1;
              done_tgl_q <= ~done_tgl_q;
              m_st_q <= M_IDLE;
            end
          end else if (hi_q && (cnt_q == '0 || !scl_s)) begin
            m_scl_low_q <= 1'b1;
            cnt_q <= LOW_CNT;
            if (bit_q == ACK_BIT) begin
              m_empty_q <= 1'b0;
              res_data_q <= sh_q;
              res_ack_q <= rx_ack_q;
              done_tgl_q <= ~done_tgl_q;
              m_st_q <= M_IDLE;
            end else begin
              // arbitration is checked on the eight data bits of a write, not on the ninth
              bit_q <= bit_q + 1'b1;
              m_st_q <= M_BIT_LOW;
            end
          end else if (hi_q) begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        M_STOP_LOW: begin
          if (cnt_q == DRIVE_PT) begin
            m_sda_low_q <= 1'b1;
          end
          if (cnt_q == '0) begin
            m_scl_low_q <= 1'b0;
            cnt_q <= STOP_CNT;
            m_st_q <= M_STOP_HIGH;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        M_STOP_HIGH: begin
          // stop setup counts from the rise
          if (!scl_s) begin
            cnt_q <= STOP_CNT;
          end else if (cnt_q == '0) begin
            m_sda_low_q <= 1'b0;
            cnt_q <= BUF_CNT;
            m_st_q <= M_STOP_BUF;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        M_STOP_BUF: begin
          if (cnt_q == '0) begin
            m_own_q <= 1'b0;
            done_tgl_q <= ~done_tgl_q;
            m_st_q <= M_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          m_st_q <= M_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // slave receiver
  // ----------------------------------------------------------------
  // own addresses with the top four bits all set never match
  assign own_hit = slv_en_s && s_sh_q[7:1] == own_s && own_s[6:3] != RSVD_TOP;
  assign gc_hit = gc_en_s && s_sh_q[7:1] == GC_ADDR;

  always_ff @(posedge bus_clk) begin
    if (lrst) begin
      s_st_q <= S_IDLE;
      s_bit_q <= 4'h0;
      s_sh_q <= 8'h00;
      s_drive_q <= 1'b0;
      s_gc_q <= 1'b0;
      slv_tgl_q <= 1'b0;
      slv_byte_q <= 8'h00;
      slv_byte_gc_q <= 1'b0;
    end else if (start_det) begin
      // a repeated start also restarts address matching
      s_st_q <= S_ADDR;
      s_bit_q <= 4'h0;
      s_drive_q <= 1'b0;
    end else if (stop_det) begin
      s_st_q <= S_IDLE;
      s_drive_q <= 1'b0;
    end else begin
      unique case (s_st_q)
        S_ADDR, S_DATA: begin
          if (scl_rise) begin
            s_sh_q <= {s_sh_q[6:0], sda_s};
            s_bit_q <= s_bit_q + 1'b1;
          end else if (scl_fall && s_bit_q == ACK_BIT) begin
            s_bit_q <= 4'h0;
            if (s_st_q == S_DATA) begin
              // byte done, answer in ninth bit
              slv_byte_q <= s_sh_q;
              slv_byte_gc_q <= s_gc_q;
              slv_tgl_q <= ~slv_tgl_q;
              // nack when slv_ack_en is low
              s_drive_q <= slv_ack_s;
              s_st_q <= S_DATA_ACK;
            end else if ((own_hit || gc_hit) && s_sh_q[0] != DIR_READ && !m_own_q) begin
              // pull data low in the ninth clock
              s_drive_q <= 1'b1;
              s_gc_q <= gc_hit && !own_hit;
              s_st_q <= S_ADDR_ACK;
            end else begin
              s_st_q <= S_IGNORE;
            end
          end
        end
        S_ADDR_ACK, S_DATA_ACK: begin
          if (scl_fall) begin
            s_drive_q <= 1'b0;
            s_st_q <= S_DATA;
          end
        end
        S_IDLE, S_IGNORE: begin
          s_drive_q <= 1'b0;
        end
        default: begin
          s_st_q <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // pull low or release, never drive high
  always_ff @(posedge bus_clk) begin
    if (lrst) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      pin_lvl_q <= 1'b0;
    end else begin
      scl_oe_q <= m_scl_low_q;
      sda_oe_q <= m_sda_low_q || s_drive_q;
      pin_lvl_q <= 1'b0;
    end
  end

  assign scl_o = pin_lvl_q;
  assign scl_oe = scl_oe_q;
  assign sda_o = pin_lvl_q;
  assign sda_oe = sda_oe_q;
  assign cmd_ready = cmd_rdy_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_ack = rsp_ack_q;
  assign rsp_arb_lost = rsp_arb_q;
  assign rsp_err = rsp_err_q;
  assign slv_valid = slv_valid_q;
  assign slv_data = slv_data_q;
  assign slv_gc = slv_gc_q;
  assign bus_busy = bus_busy_q;
endmodule : twbpe_engine

/* bench/twbpe_engine_properties.sv */
// assertions on the protocol engine ports
`timescale 1ns/100ps
module twbpe_engine_props
  import twbpe_pkg::*;
(
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic bus_clk, // link clock
  input wire logic scl_i, // clock line
  input wire logic scl_o, // clock drive
  input wire logic scl_oe, // clock pull
  input wire logic sda_o, // data drive
  input wire logic sda_oe, // data pull
  input wire logic cmd_valid, // offered
  input wire logic cmd_ready, // free
  input wire twbpe_pkg::twbpe_op_t cmd_op, // code
  input wire logic rsp_valid, // done
  input wire logic rsp_err, // refused
  input wire logic rsp_arb_lost, // lost
  input wire logic bus_busy // busy
);
  twbpe_op_t last_q;
  twbpe_op_t prev_q;
  logic [7:0] hi_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_q <= OP_STOP;
      prev_q <= OP_STOP;
    end else if (cmd_valid && cmd_ready) begin
      prev_q <= last_q;
      last_q <= cmd_op;
    end
  end
  // released high time of the clock line
  always_ff @(posedge bus_clk) begin
    if (sys_rst || scl_oe || !scl_i) begin
      hi_q <= 8'h00;
    end else if (hi_q != 8'hFF) begin
      hi_q <= hi_q + 8'h01;
    end
  end
  a_drive_low_only: assert property (@(posedge bus_clk) disable iff (sys_rst) !scl_o && !sda_o)
    else $error("drive value not low");
  a_start_then_clock: assert property (
    @(posedge bus_clk) disable iff (sys_rst) $rose(sda_oe) && scl_i && !scl_oe |-> ##[1:150] scl_oe)
    else $error("start not followed by clock low");
  a_high_from_rise: assert property (
    @(posedge bus_clk) disable iff (sys_rst) $rose(scl_oe) && $past(scl_i) |-> $past(hi_q) >= 8'h5F)
    else $error("clock high phase too short");
  a_arb_release: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid && rsp_arb_lost |-> !sda_oe && !scl_oe)
    else $error("lines held after lost arbitration");
  a_busy_on_start: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid && last_q == OP_START && !rsp_err && !rsp_arb_lost |-> bus_busy)
    else $error("bus not busy after start");
  a_free_on_stop: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid && last_q == OP_STOP && !rsp_err |-> !bus_busy)
    else $error("bus busy after stop");
  a_empty_refused: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid && last_q == OP_STOP && prev_q == OP_START |-> rsp_err)
    else $error("empty message accepted");
  a_ready_drops: assert property (@(posedge clk) disable iff (sys_rst) cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stayed high after take");
endmodule : twbpe_engine_props

bind twbpe_engine twbpe_engine_props i_twbpe_engine_props (.clk, .sys_rst, .bus_clk, .scl_i, .scl_o, .scl_oe,
  .sda_o, .sda_oe, .cmd_valid, .cmd_ready, .cmd_op, .rsp_valid, .rsp_err, .rsp_arb_lost, .bus_busy);

/* bench/twbpe_bus_model.sv */
// behavioural peer slave on the shared two-wire lines
`timescale 1ns/100ps
module twbpe_bus_model #(
  parameter logic [6:0] ADDR = 7'h2A, // own address
  parameter logic [7:0] RD_BYTE = 8'hB1 // read reply
) (
  input wire logic scl, // clock line
  input wire logic sda, // data line
  input wire logic jam, // hold data low
  input wire logic stretch, // stretch low phase
  output logic scl_pull, // pull clock low
  output logic sda_pull, // pull data low
  output logic [7:0] got // last byte written
);
  int n = 0;
  logic [8:0] sh = 9'h000;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic adr = 1'b0;
  logic jam_q = 1'b0;
  logic drv = 1'b0;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    got = 8'h00;
  end
  always @(negedge sda) begin
    if (scl) begin
      n = 0;
      adr = 1'b1;
      sel = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      sel = 1'b0;
    end
  end
  always @(negedge jam) begin
    jam_q = 1'b0;
    sda_pull = drv;
  end
  always @(posedge scl) begin
    sh = {sh[7:0], sda};
    n++;
  end
  always @(negedge scl) begin
    #1;
    jam_q = jam;
    if (n == 8) begin
      if (adr) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
      end else if (sel && !rd) begin
        got = sh[7:0];
      end
      drv = sel && (adr || !rd);
      adr = 1'b0;
    end else begin
      if (n == 9) begin
        n = 0;
        if (rd && sh[0]) sel = 1'b0;
      end
      drv = sel && rd && !RD_BYTE[7 - n];
    end
    sda_pull = drv || jam_q;
    if (stretch) begin
      scl_pull = 1'b1;
      #2000;
      scl_pull = 1'b0;
    end
  end
endmodule : twbpe_bus_model

/* bench/two_wire_bus_protocol_engine_tb_top.sv */
// self-checking bench for the two-wire protocol engine
`timescale 1ns/100ps
module two_wire_bus_protocol_engine_tb_top;
  import twbpe_pkg::*;
  localparam logic [6:0] PEER = 7'h2A;
  logic clk, bus_clk, sys_rst, cmd_valid, cmd_ack, jam, stretch, cmd_ready, rsp_valid, rsp_ack, rsp_arb_lost;
  logic rsp_err, bus_busy, scl_oe, sda_oe, scl_pull, sda_pull, slv_valid;
  logic [7:0] cmd_data, rsp_data, got;
  twbpe_op_t cmd_op;
  int fail_count, checks_done;
  wire scl = !(scl_oe || scl_pull);
  wire sda = !(sda_oe || sda_pull);
  twbpe_engine i_twbpe_engine (.clk, .sys_rst, .bus_clk, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(),
    .sda_oe, .cmd_valid, .cmd_ready, .cmd_op, .cmd_data, .cmd_ack, .rsp_valid, .rsp_data, .rsp_ack, .rsp_arb_lost,
    .rsp_err, .own_addr(7'h33), .gc_en(1'b1), .slv_en(1'b1), .slv_ack_en(1'b1), .slv_valid, .slv_data(),
    .slv_gc(), .bus_busy);
  twbpe_bus_model #(.ADDR(PEER)) i_twbpe_bus_model (.scl, .sda, .jam, .stretch, .scl_pull, .sda_pull, .got);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    bus_clk = 1'b0;
    #1.3;
    forever #3 bus_clk = ~bus_clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cmd(input twbpe_op_t op, input logic [7:0] d, input logic a);
    int n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    chk("rsp_valid", 8'h01, 8'(rsp_valid));
  endtask : cmd
  task automatic t_write;
    cmd(OP_START, 8'h00, 1'b0);
    chk("busy", 8'h01, 8'(bus_busy));
    cmd(OP_WRITE, {PEER, 1'b0}, 1'b0);
    chk("addr ack", 8'h01, 8'(rsp_ack));
    cmd(OP_WRITE, 8'hC5, 1'b0);
    chk("peer byte", 8'hC5, got);
    chk("own slave quiet", 8'h00, 8'(slv_valid));
    cmd(OP_STOP, 8'h00, 1'b0);
    chk("busy", 8'h00, 8'(bus_busy));
  endtask : t_write
  task automatic t_read;
    stretch = 1'b1;
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_WRITE, {PEER, 1'b0}, 1'b0);
    cmd(OP_START, 8'h00, 1'b0);
    chk("busy", 8'h01, 8'(bus_busy));
    cmd(OP_WRITE, {PEER, 1'b1}, 1'b0);
    chk("read ack", 8'h01, 8'(rsp_ack));
    cmd(OP_READ, 8'h00, 1'b1);
    chk("read byte", 8'hB1, rsp_data);
    chk("sent ack", 8'h01, 8'(rsp_ack));
    cmd(OP_READ, 8'h00, 1'b0);
    chk("sent nack", 8'h00, 8'(rsp_ack));
    cmd(OP_STOP, 8'h00, 1'b0);
    stretch = 1'b0;
  endtask : t_read
  task automatic t_misuse;
    cmd(OP_WRITE, 8'h55, 1'b0);
    chk("not owner", 8'h01, 8'(rsp_err));
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_STOP, 8'h00, 1'b0);
    chk("empty", 8'h01, 8'(rsp_err));
    cmd(OP_WRITE, 8'h01, 1'b0);
    chk("gc read", 8'h01, 8'(rsp_err));
    cmd(OP_WRITE, 8'h22, 1'b0);
    chk("no ack", 8'h00, 8'(rsp_ack));
    cmd(OP_STOP, 8'h00, 1'b0);
  endtask : t_misuse
  task automatic t_arb;
    // the peer holds the data line low, so the first high bit loses arbitration
    jam = 1'b1;
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_WRITE, 8'hF0, 1'b0);
    chk("arb lost", 8'h01, 8'(rsp_arb_lost));
    jam = 1'b0;
    cmd(OP_WRITE, 8'h55, 1'b0);
    chk("dropped", 8'h01, 8'(rsp_err));
  endtask : t_arb
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #400000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    jam = 1'b0;
    stretch = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    t_write;
    t_read;
    t_misuse;
    t_arb;
    tally_and_finish;
  end
endmodule : two_wire_bus_protocol_engine_tb_top
